/* File: logic/txbss_top.sv */
// Operation
// - Two-bit read/write speed select, reset to 00, picks backplane speed mode.
// - Multiplex enable changes how speed select is read; four plain codes need it off.
// - Code 00 is base rate; serial clock in at 1.544MHz or out at 1.5625MHz, base data in.
// - Base rate: multiframe sync marks superframes, every 3ms ESF or 1.5ms SF.
// - Base rate: frame sync marks each 125 us frame boundary.
// - Code 01: 2.048 rate, multiframe sync pin is the 2.048MHz data clock.
// - Code 10: 4.096 rate, multiframe sync pin is the 4.096MHz data clock.
// - Code 11: 8.192 rate, multiframe sync pin is the 8.192MHz data clock.
// - High-speed: frame sync marks frames or superframes per config bit 5.
// - Multiplex on with 00: 12.352 bit-interleaved data split over four channels.
`timescale 1ns/1ps
module txbss_top #(
  parameter int unsigned SERCLK_HALF = txbss_pkg::SERCLK_HALF
) (
  input  wire logic                  clock,              // System clock
  input  wire logic                  rst,                // Sync reset, high
  input  wire logic                  link_clk,           // Backplane sampling clock
  input  wire logic [3:0]            avs_address,        // Byte address
  input  wire logic                  avs_read,           // Read request
  input  wire logic                  avs_write,          // Write request
  input  wire logic [31:0]           avs_writedata,      // Write data
  input  wire logic [3:0]            avs_byteenable,     // Byte lanes
  output logic [31:0]                avs_readdata,       // Read data
  output logic                       avs_waitrequest,    // Stall
  input  wire logic                  tx_serial_clock_i,  // Serial clock pin in
  output logic                       tx_serial_clock_o,  // Serial clock pin out
  output logic                       tx_serial_clock_oe, // Serial clock drive enable
  input  wire logic                  tx_multiframe_sync, // Multiframe sync or fast clock
  input  wire logic                  tx_frame_sync,      // Frame sync pin
  input  wire logic                  tx_serial_data_in,  // Serial data pin
  output logic                       word_valid,         // New word, one cycle
  output txbss_pkg::txbss_word_t     word,               // Received byte and flags
  output txbss_pkg::txbss_mode_t     mode                // Decoded speed mode
);

  // ---------------- System domain ----------------
  logic [7:0]             ctrl_r;
  logic [7:0]             fcfg_r;
  logic                   ack_r;
  logic [31:0]            rdata_r;
  logic [31:0]            rd_nxt;
  txbss_pkg::txbss_mode_t mode_r;
  txbss_pkg::txbss_word_t word_r;
  logic                   word_valid_r;
  logic                   r1_r;
  logic                   r2_r;
  logic                   r3_r;
  logic                   req_st_r;
  logic                   sack_r;
  logic [15:0]            div_r;
  logic                   sclk_r;
  logic                   cko_en;

  // One wait state on every access
  always_comb avs_waitrequest = (avs_read | avs_write) & ~ack_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r <= txbss_pkg::CTRL_RST;
      fcfg_r <= txbss_pkg::FCFG_RST;
    end else if (avs_write && ack_r && avs_byteenable[0]) begin
      case (avs_address)
        txbss_pkg::CTRL_OFS: ctrl_r <= {3'h0, avs_writedata[4:0]};
        txbss_pkg::FCFG_OFS: fcfg_r <= avs_writedata[7:0] & 8'h21;
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_nxt = 32'h0;
    case (avs_address)
      txbss_pkg::CTRL_OFS: rd_nxt = {24'h0, ctrl_r};
      txbss_pkg::FCFG_OFS: rd_nxt = {24'h0, fcfg_r};
      txbss_pkg::STAT_OFS: rd_nxt = {16'h0,
                                      mode_r == txbss_pkg::MODE_OFF,
                                      mode_r == txbss_pkg::MODE_MUX12,
                                      word_r};
      default:             rd_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_r <= 32'h0;
    end else if (avs_read && !ack_r) begin
      rdata_r <= rd_nxt;
    end
  end

  assign avs_readdata = rdata_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      mode_r <= txbss_pkg::MODE_BASE;
    end else begin
      mode_r <= txbss_pkg::txbss_decode(ctrl_r[txbss_pkg::CTRL_MUX_BIT],
                                        ctrl_r[1:0]);
    end
  end

  assign mode = mode_r;

  // Serial clock is only ever driven in base rate; high speed leaves it to the far end
  assign cko_en = (mode_r == txbss_pkg::MODE_BASE) & fcfg_r[txbss_pkg::FCFG_CKO_BIT];

  // Divider gives the nearest rate above the nominal one, not exactly 1.544MHz
  always_ff @(posedge clock) begin
    if (rst || !cko_en) begin
      div_r  <= 16'h0;
      sclk_r <= 1'b0;
    end else if (div_r == 16'(SERCLK_HALF - 1)) begin
      div_r  <= 16'h0;
      sclk_r <= ~sclk_r;
    end else begin
      div_r  <= div_r + 16'h1;
    end
  end

  assign tx_serial_clock_o  = sclk_r;
  assign tx_serial_clock_oe = cko_en;

  // ---------------- Link domain ----------------
  logic                   lrst1_r;
  logic                   lrst2_r;
  logic                   lrst3_r;
  logic                   lrst_r;
  logic [3:0]             pins;
  logic [3:0]             p1_r;
  logic [3:0]             p2_r;
  logic [3:0]             p3_r;
  logic [3:0]             pin_r;
  logic [3:0]             pin_q_r;
  logic [4:0]             c1_r;
  logic [4:0]             c2_r;
  logic [4:0]             c3_r;
  logic [4:0]             cfg_r;
  txbss_pkg::txbss_mode_t lmode;
  logic                   is_base;
  logic                   is_mux;
  logic                   is_hs;
  logic                   dclk;
  logic                   dclk_q;
  logic                   smp;
  logic                   fs_prev_r;
  logic                   ms_prev_r;
  logic                   fs_bnd;
  logic                   sf_bnd;
  logic                   seen_r;
  logic [10:0]            bpf;
  logic [10:0]            cnt_r;
  logic [10:0]            idx;
  logic [10:0]            cbit;
  logic [10:0]            pos;
  logic [1:0]             chan;
  logic                   has_f;
  logic                   emit;
  logic [7:0]             shreg_r [4];
  logic [3:0]             fpend_r;
  logic [3:0]             spend_r;
  logic [3:0]             mpend_r;
  logic                   lost_r;
  logic                   req_r;
  logic                   a1_r;
  logic                   a2_r;
  logic                   a3_r;
  logic                   ack_st_r;
  txbss_pkg::txbss_word_t hold_r;
  logic                   busy;

  // Reset comes from the system clock, so it is filtered like a pin
  always_ff @(posedge link_clk) begin
    lrst1_r <= rst;
    lrst2_r <= lrst1_r;
    lrst3_r <= lrst2_r;
    if (lrst2_r == lrst3_r) begin
      lrst_r <= lrst3_r;
    end
  end

  assign pins = {tx_serial_data_in, tx_frame_sync, tx_multiframe_sync, tx_serial_clock_i};

  always_ff @(posedge link_clk) begin
    p1_r <= pins;
    p2_r <= p1_r;
    p3_r <= p2_r;
    c1_r <= {fcfg_r[txbss_pkg::FCFG_SFS_BIT], ctrl_r[3:0]};
    c2_r <= c1_r;
    c3_r <= c2_r;
  end

  // Each pin settles on its own once two stages agree
  for (genvar g = 0; g < 4; g++) begin : g_pin
    always_ff @(posedge link_clk) begin
      if (lrst_r) begin
        pin_r[g] <= 1'b0;
      end else if (p2_r[g] == p3_r[g]) begin
        pin_r[g] <= p3_r[g];
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      pin_q_r <= 4'h0;
      cfg_r   <= 5'h0;
    end else begin
      pin_q_r <= pin_r;
      if (c2_r == c3_r) begin
        cfg_r <= c3_r;
      end
    end
  end

  assign lmode   = txbss_pkg::txbss_decode(cfg_r[txbss_pkg::CTRL_MUX_BIT], cfg_r[1:0]);
  assign is_base = lmode == txbss_pkg::MODE_BASE;
  assign is_mux  = lmode == txbss_pkg::MODE_MUX12;
  assign is_hs   = (lmode == txbss_pkg::MODE_HS2) | (lmode == txbss_pkg::MODE_HS4) |
                   (lmode == txbss_pkg::MODE_HS8);

  // The three high-speed modes clock data on the multiframe sync pin
  assign dclk   = is_hs ? pin_r[txbss_pkg::PIN_MS] : pin_r[txbss_pkg::PIN_CLK];
  assign dclk_q = is_hs ? pin_q_r[txbss_pkg::PIN_MS] : pin_q_r[txbss_pkg::PIN_CLK];

  // Sample opposite the launch edge; inversion only exists at base rate
  assign smp = (lmode != txbss_pkg::MODE_OFF) &
               ((is_base & cfg_r[txbss_pkg::CTRL_INV_BIT]) ? (dclk & ~dclk_q)
                                                            : (~dclk & dclk_q));

  assign fs_bnd = pin_r[txbss_pkg::PIN_FS] & ~fs_prev_r;
  assign sf_bnd = is_base ? (pin_r[txbss_pkg::PIN_MS] & ~ms_prev_r)
                          : (is_hs & cfg_r[4] & fs_bnd);

  assign bpf   = txbss_pkg::txbss_bpf(lmode);
  assign idx   = fs_bnd ? 11'h0 : cnt_r;
  assign chan  = is_mux ? idx[1:0] : 2'h0;
  assign cbit  = is_mux ? {2'h0, idx[10:2]} : idx;
  assign has_f = is_base | is_mux;
  assign pos   = cbit - {10'h0, has_f};
  assign emit  = smp & ~(has_f & (cbit == 11'h0)) & (pos[2:0] == 3'h7);
  assign busy  = req_r != ack_st_r;

  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      fs_prev_r <= 1'b0;
      ms_prev_r <= 1'b0;
      cnt_r     <= 11'h0;
      seen_r    <= 1'b0;
    end else if (smp) begin
      fs_prev_r <= pin_r[txbss_pkg::PIN_FS];
      ms_prev_r <= pin_r[txbss_pkg::PIN_MS];
      cnt_r     <= (idx == bpf - 11'h1) ? 11'h0 : idx + 11'h1;
      if (fs_bnd) begin
        seen_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      for (int i = 0; i < 4; i++) begin
        shreg_r[i] <= 8'h0;
      end
    end else if (smp) begin
      shreg_r[chan] <= {shreg_r[chan][6:0], pin_r[txbss_pkg::PIN_DAT]};
    end
  end

  // Boundary flags ride on the next byte of each channel; a new mark wins over clearing
  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      fpend_r <= 4'h0;
      spend_r <= 4'h0;
      mpend_r <= 4'h0;
    end else if (smp) begin
      if (emit) begin
        fpend_r[chan] <= 1'b0;
        spend_r[chan] <= 1'b0;
        mpend_r[chan] <= 1'b0;
      end
      if (idx == 11'h0) begin
        fpend_r <= 4'hf;
      end
      if (sf_bnd) begin
        spend_r <= 4'hf;
      end
      if (fs_bnd && seen_r && cnt_r != 11'h0) begin
        mpend_r <= 4'hf;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    a1_r <= sack_r;
    a2_r <= a1_r;
    a3_r <= a2_r;
  end

  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      ack_st_r <= 1'b0;
    end else if (a2_r == a3_r) begin
      ack_st_r <= a3_r;
    end
  end

  // A byte finishing while the previous one is still in flight is dropped
  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      req_r  <= 1'b0;
      lost_r <= 1'b0;
      hold_r <= '0;
    end else if (emit) begin
      if (!busy) begin
        hold_r <= '{lost: lost_r, misframe: mpend_r[chan], superframe: spend_r[chan],
                    frame_start: fpend_r[chan], chan: chan,
                    data: {shreg_r[chan][6:0], pin_r[txbss_pkg::PIN_DAT]}};
        req_r  <= ~req_r;
        lost_r <= 1'b0;
      end else begin
        lost_r <= 1'b1;
      end
    end
  end

  // ---------------- Crossing back to system ----------------
  always_ff @(posedge clock) begin
    r1_r <= req_r;
    r2_r <= r1_r;
    r3_r <= r2_r;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      req_st_r     <= 1'b0;
      sack_r       <= 1'b0;
      word_r       <= '0;
      word_valid_r <= 1'b0;
    end else begin
      if (r2_r == r3_r) begin
        req_st_r <= r3_r;
      end
      word_valid_r <= 1'b0;
      if (req_st_r != sack_r) begin
        word_r       <= hold_r;
        word_valid_r <= 1'b1;
        sack_r       <= req_st_r;
      end
    end
  end

  assign word       = word_r;
  assign word_valid = word_valid_r;

endmodule : txbss_top

/* File: logic/txbss_pkg.sv */
package txbss_pkg;

  // Clocking
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned SERCLK_HZ     = 1_544_000;
  localparam int unsigned SERCLK_HALF   = CLK_HZ / (2 * SERCLK_HZ);

  // Frame timing and line rates
  localparam int unsigned FRAME_US      = 125;
  localparam int unsigned ESF_SPAN_US   = 3000;
  localparam int unsigned SF_SPAN_US    = 1500;
  localparam int unsigned BASE_KBPS     = 1544;
  localparam int unsigned HS2_KBPS      = 2048;
  localparam int unsigned HS4_KBPS      = 4096;
  localparam int unsigned HS8_KBPS      = 8192;
  localparam int unsigned MUX_KBPS      = 12352;
  localparam int unsigned BITS_BASE     = BASE_KBPS * FRAME_US / 1000;
  localparam int unsigned BITS_HS2      = HS2_KBPS * FRAME_US / 1000;
  localparam int unsigned BITS_HS4      = HS4_KBPS * FRAME_US / 1000;
  localparam int unsigned BITS_HS8      = HS8_KBPS * FRAME_US / 1000;
  localparam int unsigned BITS_MUX      = MUX_KBPS * FRAME_US / 1000;
  localparam int unsigned FRAMES_ESF    = ESF_SPAN_US / FRAME_US;
  localparam int unsigned FRAMES_SF     = SF_SPAN_US / FRAME_US;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFS       = 4'h0;
  localparam logic [3:0] FCFG_OFS       = 4'h4;
  localparam logic [3:0] STAT_OFS       = 4'h8;

  // Field positions
  localparam int unsigned CTRL_SEL_LSB  = 0;
  localparam int unsigned CTRL_MUX_BIT  = 2;
  localparam int unsigned CTRL_INV_BIT  = 3;
  localparam int unsigned CTRL_FRAC_BIT = 4;
  localparam int unsigned FCFG_CKO_BIT  = 0;
  localparam int unsigned FCFG_SFS_BIT  = 5;
  localparam int unsigned PIN_CLK       = 0;
  localparam int unsigned PIN_MS        = 1;
  localparam int unsigned PIN_FS        = 2;
  localparam int unsigned PIN_DAT       = 3;

  // Reset values
  localparam logic [7:0] CTRL_RST       = 8'h00;
  localparam logic [7:0] FCFG_RST       = 8'h00;

  typedef enum logic [5:0] {
    MODE_BASE  = 6'h01,
    MODE_HS2   = 6'h02,
    MODE_HS4   = 6'h04,
    MODE_HS8   = 6'h08,
    MODE_MUX12 = 6'h10,
    MODE_OFF   = 6'h20
  } txbss_mode_t;

  typedef struct packed {
    logic       lost;
    logic       misframe;
    logic       superframe;
    logic       frame_start;
    logic [1:0] chan;
    logic [7:0] data;
  } txbss_word_t;

  function automatic txbss_mode_t txbss_decode(input logic mux, input logic [1:0] sel);
    txbss_mode_t m;
    m = MODE_OFF;
    if (!mux) begin
      case (sel)
        2'h0:    m = MODE_BASE;
        2'h1:    m = MODE_HS2;
        2'h2:    m = MODE_HS4;
        default: m = MODE_HS8;
      endcase
    end else if (sel == 2'h0) begin
      m = MODE_MUX12;
    end
    return m;
  endfunction : txbss_decode

  function automatic logic [10:0] txbss_bpf(input txbss_mode_t m);
    logic [10:0] b;
    b = 11'(BITS_BASE);
    case (m)
      MODE_HS2:   b = 11'(BITS_HS2);
      MODE_HS4:   b = 11'(BITS_HS4);
      MODE_HS8:   b = 11'(BITS_HS8);
      MODE_MUX12: b = 11'(BITS_MUX);
      default:    b = 11'(BITS_BASE);
    endcase
    return b;
  endfunction : txbss_bpf

endpackage : txbss_pkg

/* File: test/txbss_assertions.sv */
`timescale 1ns/1ps
module txbss_checker (
  input wire logic                   clock,              // Clock
  input wire logic                   rst,                // Reset
  input wire logic [3:0]             avs_address,        // Address
  input wire logic                   avs_read,           // Read
  input wire logic                   avs_write,          // Write
  input wire logic [31:0]            avs_writedata,      // Write data
  input wire logic [3:0]             avs_byteenable,     // Lanes
  input wire logic                   avs_waitrequest,    // Stall
  input wire logic                   tx_serial_clock_oe, // Clock drive
  input wire logic                   word_valid,         // Word strobe
  input wire txbss_pkg::txbss_mode_t mode                // Mode
);
  logic       wc;
  logic [2:0] wv;
  assign wc = avs_write & ~avs_waitrequest & avs_byteenable[0]
              & (avs_address == txbss_pkg::CTRL_OFS);
  assign wv = avs_writedata[2:0];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_RST_MODE: assert property ($fell(rst) |-> mode == txbss_pkg::MODE_BASE)
    else $error("mode not base after reset");
  AST_BASE: assert property (wc && wv == 3'h0 |-> ##[1:3] mode == txbss_pkg::MODE_BASE)
    else $error("code 00 not base");
  AST_HS2: assert property (wc && wv == 3'h1 |-> ##[1:3] mode == txbss_pkg::MODE_HS2)
    else $error("code 01 not hs2");
  AST_HS4: assert property (wc && wv == 3'h2 |-> ##[1:3] mode == txbss_pkg::MODE_HS4)
    else $error("code 10 not hs4");
  AST_HS8: assert property (wc && wv == 3'h3 |-> ##[1:3] mode == txbss_pkg::MODE_HS8)
    else $error("code 11 not hs8");
  AST_MUX: assert property (wc && wv == 3'h4 |-> ##[1:3] mode == txbss_pkg::MODE_MUX12)
    else $error("mux 00 not mux12");
  AST_OFF: assert property (wc && wv[2] && wv[1:0] != 2'h0 |-> ##[1:3]
    mode == txbss_pkg::MODE_OFF) else $error("mux code not off");
  AST_OE_HS: assert property ((mode != txbss_pkg::MODE_BASE)[*3] |-> !tx_serial_clock_oe)
    else $error("serial clock driven outside base");
  AST_WV_PULSE: assert property (word_valid |=> !word_valid)
    else $error("word strobe too long");
  AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("more than one wait state");
endmodule : txbss_checker

bind txbss_top txbss_checker i_txbss_checker (.clock, .rst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .tx_serial_clock_oe,
  .word_valid, .mode);

/* File: test/txbss_backplane.sv */
`timescale 1ns/1ps
module txbss_backplane (
  input  wire logic hs,      // High-speed mode
  output logic      ser_clk, // Serial clock pin
  output logic      msync,   // Multiframe sync or fast clock
  output logic      fsync,   // Frame sync
  output logic      sdata    // Serial data
);
  // Slow against the link clock so the pin filter accepts each edge
  int   half = 150;
  logic dclk = 1'h0;
  logic rclk = 1'h0;
  logic mark = 1'h0;
  always #324 rclk = hs ? ~rclk : 1'h0;
  assign ser_clk = hs ? rclk : dclk;
  assign msync = hs ? dclk : mark;
  initial begin
    fsync = 1'h0;
    sdata = 1'h0;
  end
  task automatic bit_out(input logic d, input logic fs);
    dclk = 1'h1;
    sdata = d;
    fsync = fs;
    #half dclk = 1'h0;
    #half;
  endtask : bit_out
  task automatic send(input logic sf, input logic [15:0] d);
    if (!hs) begin
      mark = sf;
      bit_out(1'h1, 1'h1);
      mark = 1'h0;
    end
    for (int i = 15; i >= 0; i--) bit_out(d[i], hs && i == 15);
    // Released line must not keep showing the last bit
    sdata = ~sdata;
  endtask : send
endmodule : txbss_backplane

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb;
  logic                   clock = 1'h0;
  logic                   rst = 1'h1;
  logic                   link_clk = 1'h0;
  logic [3:0]             avs_address = 4'h0;
  logic                   avs_read = 1'h0;
  logic                   avs_write = 1'h0;
  logic [31:0]            avs_writedata = 32'h0;
  logic [3:0]             avs_byteenable = 4'hf;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic                   clk_o, clk_oe, bp_clk, ser_pin, msync, fsync, sdata, word_valid;
  logic                   hs = 1'h0;
  txbss_pkg::txbss_word_t word;
  txbss_pkg::txbss_mode_t mode;
  logic [13:0]            q[$];
  logic [31:0]            seed = 32'ha36b;
  logic [31:0]            rv;
  int                     n_fail = 0;
  int                     comparisons = 0;
  int                     cycles = 0;

  assign ser_pin = clk_oe ? clk_o : bp_clk;
  initial begin
    forever #20 clock = ~clock;
  end
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end

  txbss_top i_txbss_top (.clock, .rst, .link_clk, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .tx_serial_clock_i(ser_pin), .tx_serial_clock_o(clk_o), .tx_serial_clock_oe(clk_oe),
    .tx_multiframe_sync(msync), .tx_frame_sync(fsync), .tx_serial_data_in(sdata),
    .word_valid, .word, .mode);
  txbss_backplane i_txbss_backplane (.hs, .ser_clk(bp_clk), .msync, .fsync, .sdata);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic txbss_pkg::txbss_mode_t exp_mode(input logic [2:0] c);
    if (c == 3'h4) return txbss_pkg::MODE_MUX12;
    if (c[2]) return txbss_pkg::MODE_OFF;
    case (c[1:0])
      2'h0: return txbss_pkg::MODE_BASE;
      2'h1: return txbss_pkg::MODE_HS2;
      2'h2: return txbss_pkg::MODE_HS4;
      default: return txbss_pkg::MODE_HS8;
    endcase
  endfunction : exp_mode
  // Whole word: lost, misframe, superframe, frame start, channel 0, data
  function automatic logic [31:0] exp_word(input logic mf, input logic sf, input logic fs,
                                           input logic [7:0] d);
    return {18'h0, 1'h0, mf, sf, fs, 2'h0, d};
  endfunction : exp_word

  task automatic finish_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One idle edge first so back-to-back calls never drive a strobe twice
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] v);
    @(posedge clock);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'h0);
    v = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] v;
    bus(1'h1, a, d, be, v);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] v;
    bus(1'h0, a, 32'h0, 4'hf, v);
    chk("readdata", e, v);
  endtask : rd

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (word_valid === 1'h1) q.push_back(word);
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    logic [15:0]            d;
    logic                   ss;
    logic [31:0]            v;
    txbss_pkg::txbss_mode_t m;
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    rd(txbss_pkg::CTRL_OFS, 32'h0);
    rd(txbss_pkg::FCFG_OFS, 32'h0);
    wr(txbss_pkg::CTRL_OFS, 32'hff, 4'h0);
    rd(txbss_pkg::CTRL_OFS, 32'h0);
    wr(txbss_pkg::CTRL_OFS, 32'hff, 4'hf);
    rd(txbss_pkg::CTRL_OFS, 32'h1f);
    rd(4'hc, 32'h0);
    for (int c = 0; c < 8; c++) begin
      m = exp_mode(3'(c));
      wr(txbss_pkg::CTRL_OFS, 32'(c), 4'hf);
      repeat (4) @(posedge clock);
      chk("mode", {26'h0, m}, {26'h0, mode});
      bus(1'h0, txbss_pkg::STAT_OFS, 32'h0, 4'hf, v);
      chk("stat_mode", {30'h0, m == txbss_pkg::MODE_OFF,
          m == txbss_pkg::MODE_MUX12}, {30'h0, v[15:14]});
    end
    wr(txbss_pkg::CTRL_OFS, 32'h0, 4'hf);
    wr(txbss_pkg::FCFG_OFS, 32'h1, 4'hf);
    repeat (4) @(posedge clock);
    chk("clock_oe", 32'h1, {31'h0, clk_oe});
    v = {31'h0, clk_o};
    repeat (txbss_pkg::SERCLK_HALF) @(posedge clock);
    chk("clock_o", {31'h0, ~v[0]}, {31'h0, clk_o});
    wr(txbss_pkg::CTRL_OFS, 32'h1, 4'hf);
    repeat (4) @(posedge clock);
    chk("clock_oe", 32'h0, {31'h0, clk_oe});
    for (int k = 0; k < 8; k++) begin
      rv = rnd();
      d = (k == 0) ? 16'h80ff : rv[15:0];
      // Park the serial clock across the mode change; a stray fall would count as a bit
      hs <= 1'h0;
      wr(txbss_pkg::FCFG_OFS, {26'h0, rv[20], 5'h0}, 4'hf);
      wr(txbss_pkg::CTRL_OFS, {30'h0, 2'(k)}, 4'hf);
      repeat (4) @(posedge clock);
      hs <= (2'(k) != 2'h0);
      repeat (4) @(posedge clock);
      q.delete();
      ss = hs ? rv[20] : rv[16];
      i_txbss_backplane.send(rv[16], d);
      repeat (30) @(posedge clock);
      chk("words", 32'h2, 32'(q.size()));
      if (q.size() == 2) begin
        // Every send after the first finds the bit counter away from its wrap
        chk("first", exp_word(k != 0, ss, 1'h1, d[15:8]), {18'h0, q[0]});
        chk("second", exp_word(1'h0, 1'h0, 1'h0, d[7:0]), {18'h0, q[1]});
      end
    end
    finish_test();
  end
endmodule : tb
